// ==== core/gpr_ramp_engine.sv ====
/*
 * Gain sequencer of a multichannel amplifier front end with an AXI4-Lite register slave.
 * Assumes start_pulse and all inputs are synchronous to aclk, the device input clock.
 */
// Notes on behaviour
// - Uniform mode ramps gain up from start level at the slope-count rate.
// - End level is computed, never written.
// - Fine stepping holds each level slope sample periods, then adds 0.125dB.
// - Coarse stepping holds slope times 8 sample periods, then adds 1dB.
// - End level is start plus index difference, plus 0.875dB when fine.
// - Index values only matter through their difference.
// - Only rising ramps; a negative index difference counts as zero.
// - After the ramp, hold for hold time plus one sample periods, then fall 1dB per sample period.
// - Coarse stepping dwells one full step interval at the end level.
// - Fine stepping adds seven fine steps past the coarse end level, then dwells one interval.
// - Fixed-gain select freezes gain at coarse plus fine setting.
// - Coarse word selects -5 to 31dB, codes 0x00 to 0x24.
// - Coarse codes above 0x24 behave as 0x24.
// - Fine word adds 0 to 0.875dB in 0.125dB steps.
// - One cutoff setting applies to all channels: 7.5, 10 or 14MHz.
// - Clamp active after reset; bit 14 of register 70 turns it off.
// - Even and odd channels sampled on alternate input clock edges.
// - Clock buffer enabled unless the negative clock input is grounded.
// - Start pulse is taken on a sampling clock edge.
// - Soft trigger repeats ramp, hold and return until cleared.
// - Gain code maps to -5dB plus code times 0.125dB.
`timescale 1ns/1ps
`default_nettype none
`include "gpr_regs.svh"

module gpr_ramp_engine #(
  parameter int ADDR_W = 12,
  parameter int HOLD_W = 16
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic start_pulse,
  input wire logic clock_input_negative_grounded,
  output logic [8:0] gain_code,
  output logic engine_busy,
  output logic clamp_enable,
  output logic [1:0] lowpass_cutoff_select,
  output logic clock_buffer_enable,
  output logic even_sample_strobe,
  output logic odd_sample_strobe
);

  // ==========================================
  // Elaboration checks
  generate
    if (ADDR_W < 10 || ADDR_W > 32)
    begin : g_bad_addr
      $error("ADDR_W must lie between 10 and 32");
    end
    if (HOLD_W < 1 || HOLD_W > 16)
    begin : g_bad_hold
      $error("HOLD_W must lie between 1 and 16");
    end
  endgenerate

  localparam int NREG = 8;

  // ==========================================
  // Decoding helpers
  function automatic logic [3:0] slot_of(input logic [ADDR_W-1:0] a);
    logic [7:0] idx;
    idx = a[9:2];
    slot_of = 4'hF;
    if (a[1:0] == 2'b00 && a[ADDR_W-1:10] == '0)
    begin
      unique case (idx)
        `GPR_IDX_GEN: slot_of = 4'h0;
        `GPR_IDX_FIXED: slot_of = 4'h1;
        `GPR_IDX_COARSE: slot_of = 4'h2;
        `GPR_IDX_SLOPE: slot_of = 4'h3;
        `GPR_IDX_CTRL: slot_of = 4'h4;
        `GPR_IDX_START: slot_of = 4'h5;
        `GPR_IDX_INDEX: slot_of = 4'h6;
        `GPR_IDX_HOLD: slot_of = 4'h7;
        `GPR_IDX_STATUS: slot_of = 4'h8;
        default: slot_of = 4'hF;
      endcase
    end
  endfunction

  function automatic logic [31:0] mask_of(input int s);
    unique case (s)
      0: mask_of = `GPR_MASK_GEN;
      1: mask_of = `GPR_MASK_FIXED;
      2: mask_of = `GPR_MASK_COARSE;
      3: mask_of = `GPR_MASK_SLOPE;
      4: mask_of = `GPR_MASK_CTRL;
      5: mask_of = `GPR_MASK_START;
      6: mask_of = `GPR_MASK_INDEX;
      default: mask_of = `GPR_MASK_HOLD;
    endcase
  endfunction

  // Coarse and start codes share one saturation.
  function automatic logic [5:0] sat_code(input logic [5:0] c);
    sat_code = (c > `GPR_COARSE_MAX) ? `GPR_COARSE_MAX : c;
  endfunction

  // ==========================================
  // Register storage and write channel
  logic [31:0] regs_q [NREG];
  logic aw_full_q;
  logic w_full_q;
  logic [ADDR_W-1:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic do_write;
  logic [3:0] wslot;
  logic [31:0] wmerge;

  assign s_axi_awready = !aw_full_q && !bvalid_q;
  assign s_axi_wready = !w_full_q && !bvalid_q;
  assign do_write = aw_full_q && w_full_q && !bvalid_q;
  assign wslot = slot_of(awaddr_q);
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;

  always_comb
  begin
    wmerge = '0;
    for (int b = 0; b < 4; b++)
    begin
      wmerge[b*8 +: 8] = wstrb_q[b] ? wdata_q[b*8 +: 8] : 8'h00;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_full_q <= 1'b0;
      awaddr_q <= '0;
    end
    else if (s_axi_awvalid && s_axi_awready)
    begin
      aw_full_q <= 1'b1;
      awaddr_q <= s_axi_awaddr;
    end
    else if (do_write)
    begin
      aw_full_q <= 1'b0;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      w_full_q <= 1'b0;
      wdata_q <= '0;
      wstrb_q <= '0;
    end
    else if (s_axi_wvalid && s_axi_wready)
    begin
      w_full_q <= 1'b1;
      wdata_q <= s_axi_wdata;
      wstrb_q <= s_axi_wstrb;
    end
    else if (do_write)
    begin
      w_full_q <= 1'b0;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      bvalid_q <= 1'b0;
      bresp_q <= 2'b00;
    end
    else if (do_write)
    begin
      bvalid_q <= 1'b1;
      bresp_q <= (wslot == 4'hF) ? 2'b10 : 2'b00;
    end
    else if (s_axi_bready)
    begin
      bvalid_q <= 1'b0;
    end
  end

  // Partial strobes keep the unstrobed bytes of the old value.
  always_ff @(posedge aclk)
  begin
    for (int i = 0; i < NREG; i++)
    begin
      if (!aresetn)
      begin
        regs_q[i] <= (i == 3) ? `GPR_RST_SLOPE : `GPR_RST_ALL;
      end
      else if (do_write && wslot == i[3:0])
      begin
        regs_q[i] <= ((regs_q[i] & ~{{8{wstrb_q[3]}}, {8{wstrb_q[2]}}, {8{wstrb_q[1]}},
                       {8{wstrb_q[0]}}}) | wmerge) & mask_of(i);
      end
    end
  end

  // ==========================================
  // Field extraction
  logic fixed_sel;
  logic uniform_sel;
  logic fine_step_select;
  logic soft_trigger;
  logic [5:0] start_code;
  logic [7:0] slope;
  logic [7:0] first_index;
  logic [7:0] last_index;
  logic [HOLD_W-1:0] hold_time;

  assign fixed_sel = regs_q[1][`GPR_FIXED_SEL];
  assign uniform_sel = regs_q[4][`GPR_CTRL_UNIFORM];
  assign fine_step_select = regs_q[4][`GPR_CTRL_FINE];
  assign soft_trigger = regs_q[4][`GPR_CTRL_SOFT];
  assign start_code = sat_code(regs_q[5][5:0]);
  assign slope = regs_q[3][7:0];
  assign first_index = regs_q[6][7:0];
  assign last_index = regs_q[6][15:8];
  assign hold_time = regs_q[7][HOLD_W-1:0];
  assign clamp_enable = !regs_q[0][`GPR_GEN_CLAMP_OFF];
  assign lowpass_cutoff_select = (regs_q[0][1:0] == 2'b11) ? 2'b10 : regs_q[0][1:0];
  assign clock_buffer_enable = !clock_input_negative_grounded;

  // ==========================================
  // Channel sampling phase
  logic phase_q;
  logic tick;

  // Each channel pair sees every second input edge, so the engine steps at half rate.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      phase_q <= 1'b0;
      even_sample_strobe <= 1'b0;
      odd_sample_strobe <= 1'b0;
    end
    else
    begin
      phase_q <= !phase_q;
      even_sample_strobe <= !phase_q;
      odd_sample_strobe <= phase_q;
    end
  end

  assign tick = phase_q;

  // ==========================================
  // End level and step interval
  logic [8:0] diff;
  logic [9:0] end_sum;
  gpr_pkg::gpr_gain_t start_g;
  gpr_pkg::gpr_gain_t end_g;
  gpr_pkg::gpr_gain_t step_g;
  logic [15:0] interval;
  logic [7:0] slope_eff;

  always_comb
  begin
    // Index values are never dereferenced; only the span counts.
    diff = (last_index >= first_index) ? ({1'b0, last_index} - {1'b0, first_index})
                                       : 9'h000;
    end_sum = {4'h0, start_code} + {1'b0, diff};
    if (end_sum > {4'h0, `GPR_COARSE_MAX})
    begin
      end_sum = {4'h0, `GPR_COARSE_MAX};
    end
    end_g = {end_sum[5:0], 3'b000} + (fine_step_select ? `GPR_FINE_TOP : 9'h000);
    start_g = {start_code, 3'b000};
    step_g = fine_step_select ? 9'h001 : `GPR_STEPS_PER_DB;
    slope_eff = (slope == 8'h00) ? 8'h01 : slope;
    interval = fine_step_select ? {8'h00, slope_eff}
                                : ({8'h00, slope_eff} << `GPR_COARSE_MULT);
  end

  // ==========================================
  // Start capture
  logic pend_q;
  logic trigger;

  // A pulse that lands between sampling edges is kept until the next one.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      pend_q <= 1'b0;
    end
    else
    begin
      pend_q <= (pend_q || start_pulse) && !tick;
    end
  end

  assign trigger = tick && (pend_q || start_pulse);

  // ==========================================
  // Gain engine
  gpr_pkg::gpr_state_t state_q;
  gpr_pkg::gpr_gain_t eng_g_q;
  logic [15:0] cnt_q;
  logic soft_go;

  assign soft_go = tick && soft_trigger && uniform_sel && state_q == gpr_pkg::GPR_IDLE;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state_q <= gpr_pkg::GPR_IDLE;
      eng_g_q <= '0;
      cnt_q <= '0;
    end
    else if (fixed_sel || !uniform_sel)
    begin
      state_q <= gpr_pkg::GPR_IDLE;
      eng_g_q <= start_g;
      cnt_q <= '0;
    end
    else if (trigger || soft_go)
    begin
      state_q <= gpr_pkg::GPR_RAMP;
      eng_g_q <= start_g;
      cnt_q <= '0;
    end
    else if (tick)
    begin
      unique case (state_q)
        gpr_pkg::GPR_IDLE:
        begin
          eng_g_q <= start_g;
        end
        gpr_pkg::GPR_RAMP:
        begin
          if (cnt_q >= interval - 16'h0001)
          begin
            cnt_q <= '0;
            // At the top the full interval has already been spent there.
            if (eng_g_q >= end_g)
            begin
              state_q <= gpr_pkg::GPR_HOLD;
            end
            else
            begin
              eng_g_q <= eng_g_q + step_g;
            end
          end
          else
          begin
            cnt_q <= cnt_q + 16'h0001;
          end
        end
        gpr_pkg::GPR_HOLD:
        begin
          if (cnt_q >= {{(16-HOLD_W){1'b0}}, hold_time})
          begin
            cnt_q <= '0;
            state_q <= gpr_pkg::GPR_FALL;
          end
          else
          begin
            cnt_q <= cnt_q + 16'h0001;
          end
        end
        gpr_pkg::GPR_FALL:
        begin
          if (eng_g_q <= start_g + `GPR_STEPS_PER_DB)
          begin
            eng_g_q <= start_g;
            state_q <= gpr_pkg::GPR_IDLE;
          end
          else
          begin
            eng_g_q <= eng_g_q - `GPR_STEPS_PER_DB;
          end
        end
        default:
        begin
          state_q <= gpr_pkg::GPR_IDLE;
        end
      endcase
    end
  end

  // ==========================================
  // Gain output
  gpr_pkg::gpr_gain_t fixed_g;

  assign fixed_g = {sat_code(regs_q[2][5:0]), regs_q[1][2:0]};

  // Gain is registered on every aclk edge; in fixed mode a register write reaches it on any edge.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      gain_code <= '0;
      engine_busy <= 1'b0;
    end
    else
    begin
      gain_code <= fixed_sel ? fixed_g : eng_g_q;
      engine_busy <= state_q != gpr_pkg::GPR_IDLE;
    end
  end

  // ==========================================
  // Read channel
  logic rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0] rresp_q;
  logic [3:0] rslot;

  assign s_axi_arready = !rvalid_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;
  assign rslot = slot_of(s_axi_araddr);

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rvalid_q <= 1'b0;
      rdata_q <= '0;
      rresp_q <= 2'b00;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      rvalid_q <= 1'b1;
      rresp_q <= (rslot == 4'hF) ? 2'b10 : 2'b00;
      if (rslot == 4'h8)
      begin
        rdata_q <= {7'h00, end_g, 6'h00, engine_busy, gain_code};
      end
      else if (rslot == 4'hF)
      begin
        rdata_q <= '0;
      end
      else
      begin
        rdata_q <= regs_q[rslot[2:0]];
      end
    end
    else if (s_axi_rready)
    begin
      rvalid_q <= 1'b0;
    end
  end

endmodule
`default_nettype wire

// ==== core/gpr_regs.svh ====
/*
 * Register indices, field positions, reset values and timing counts of the gain ramp engine.
 * Assumes the including file reaches registers at byte address four times the index.
 */
`ifndef GPR_REGS_SVH
`define GPR_REGS_SVH

// ==========================================
// Register indices (byte address = 4 x index)
`define GPR_IDX_GEN 8'h46
`define GPR_IDX_FIXED 8'h99
`define GPR_IDX_COARSE 8'h9A
`define GPR_IDX_SLOPE 8'h9B
`define GPR_IDX_CTRL 8'hA0
`define GPR_IDX_START 8'hA1
`define GPR_IDX_INDEX 8'hA2
`define GPR_IDX_HOLD 8'hA3
`define GPR_IDX_STATUS 8'hA4

// ==========================================
// Writable masks, which are also the read masks
`define GPR_MASK_GEN 32'h0000_4003
`define GPR_MASK_FIXED 32'h0000_000F
`define GPR_MASK_COARSE 32'h0000_003F
`define GPR_MASK_SLOPE 32'h0000_00FF
`define GPR_MASK_CTRL 32'h0000_0007
`define GPR_MASK_START 32'h0000_003F
`define GPR_MASK_INDEX 32'h0000_FFFF
`define GPR_MASK_HOLD 32'h0000_FFFF

// ==========================================
// Field positions
`define GPR_GEN_CLAMP_OFF 14
`define GPR_FIXED_SEL 3
`define GPR_CTRL_UNIFORM 0
`define GPR_CTRL_FINE 1
`define GPR_CTRL_SOFT 2

// ==========================================
// Reset values and gain figures
`define GPR_RST_ALL 32'h0000_0000
`define GPR_RST_SLOPE 32'h0000_0001
`define GPR_COARSE_MAX 6'h24
`define GPR_FINE_TOP 9'h007
`define GPR_STEPS_PER_DB 9'h008
`define GPR_COARSE_MULT 3

`endif

// ==== core/gpr_pkg.sv ====
/*
 * Types shared by the gain ramp engine.
 * Assumes nothing of its surroundings.
 */
package gpr_pkg;

  typedef enum logic [2:0] {
    GPR_IDLE,
    GPR_RAMP,
    GPR_HOLD,
    GPR_FALL
  } gpr_state_t;

  typedef logic [8:0] gpr_gain_t;

endpackage

// ==== testbench/gpr_ramp_engine_sva.sv ====
/*
 * Port checks of the gain ramp engine.
 * Assumes it is bound to gpr_ramp_engine and that aclk is its only clock.
 */
`timescale 1ns/1ps
`default_nettype none
module gpr_ramp_engine_sva (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic clock_input_negative_grounded,
  input wire logic [8:0] gain_code,
  input wire logic engine_busy,
  input wire logic clamp_enable,
  input wire logic [1:0] lowpass_cutoff_select,
  input wire logic clock_buffer_enable,
  input wire logic even_sample_strobe,
  input wire logic odd_sample_strobe
);
  // ====
  // Properties.
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  property p_buf;
    clock_buffer_enable == !clock_input_negative_grounded;
  endproperty
  a_buf: assert property (p_buf) else $error("clock buffer enable wrong");
  property p_even;
    even_sample_strobe |=> odd_sample_strobe && !even_sample_strobe;
  endproperty
  a_even: assert property (p_even) else $error("odd strobe missing");
  property p_odd;
    odd_sample_strobe |=> even_sample_strobe;
  endproperty
  a_odd: assert property (p_odd) else $error("even strobe missing");
  property p_cut;
    lowpass_cutoff_select != 2'b11;
  endproperty
  a_cut: assert property (p_cut) else $error("cutoff code out of range");
  property p_clamp;
    $rose(aresetn) |-> clamp_enable;
  endproperty
  a_clamp: assert property (p_clamp) else $error("clamp off after reset");
  property p_max;
    gain_code <= 9'h127;
  endproperty
  a_max: assert property (p_max) else $error("gain above maximum");
  property p_bblk;
    s_axi_bvalid |-> !s_axi_awready;
  endproperty
  a_bblk: assert property (p_bblk) else $error("address taken during response");
  property p_rans;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid ##0 !s_axi_arready;
  endproperty
  a_rans: assert property (p_rans) else $error("read answer late");
  c_run: cover property ($rose(engine_busy) ##[1:400] $fell(engine_busy));
  c_write: cover property (s_axi_bvalid);
  c_read: cover property (s_axi_rvalid);
endmodule
bind gpr_ramp_engine gpr_ramp_engine_sva i_sva (
  .aclk(aclk), .aresetn(aresetn), .s_axi_awready(s_axi_awready),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
  .clock_input_negative_grounded(clock_input_negative_grounded),
  .gain_code(gain_code), .engine_busy(engine_busy), .clamp_enable(clamp_enable),
  .lowpass_cutoff_select(lowpass_cutoff_select), .clock_buffer_enable(clock_buffer_enable),
  .even_sample_strobe(even_sample_strobe), .odd_sample_strobe(odd_sample_strobe)
);
`default_nettype wire

// ==== testbench/gpr_host.sv ====
/*
 * Configuration host: AXI4-Lite master and start pulse source.
 * Assumes its tasks are called from the bench at simulation time.
 */
`timescale 1ns/1ps
`default_nettype none
module gpr_host (
  input wire logic aclk,
  output logic [11:0] awaddr,
  output logic awvalid,
  input wire logic awready,
  output logic [31:0] wdata,
  output logic [3:0] wstrb,
  output logic wvalid,
  input wire logic wready,
  input wire logic [1:0] bresp,
  input wire logic bvalid,
  output logic bready,
  output logic [11:0] araddr,
  output logic arvalid,
  input wire logic arready,
  input wire logic [1:0] rresp,
  input wire logic rvalid,
  output logic rready,
  output logic start_pulse
);
  // ====
  // Bus cycles. A response code of x means no answer came.
  initial
  begin
    {awvalid, wvalid, bready, arvalid, rready, start_pulse} = '0;
    {awaddr, araddr, wdata} = '0;
    wstrb = 4'hf;
  end
  task automatic wr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
    r = 2'bxx;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    repeat (64)
    begin
      @(posedge aclk);
      if (awvalid && awready)
        awvalid <= 1'b0;
      if (wvalid && wready)
        wvalid <= 1'b0;
      if (bvalid && bready)
      begin
        r = bresp;
        bready <= 1'b0;
        awaddr <= ~a;
        wdata <= ~d;
        break;
      end
    end
  endtask
  task automatic rd(input logic [11:0] a, output logic [1:0] r);
    r = 2'bxx;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    repeat (64)
    begin
      @(posedge aclk);
      if (arvalid && arready)
        arvalid <= 1'b0;
      if (rvalid && rready)
      begin
        r = rresp;
        rready <= 1'b0;
        araddr <= ~a;
        break;
      end
    end
  endtask
  task automatic pulse;
    @(posedge aclk);
    start_pulse <= 1'b1;
    @(posedge aclk);
    start_pulse <= 1'b0;
  endtask
endmodule
`default_nettype wire

// ==== testbench/gpr_ramp_engine_bench.sv ====
/*
 * Self-checking bench of the gain ramp engine.
 * Assumes gpr_host drives the register bus and the start pulse.
 */
`timescale 1ns/1ps
`default_nettype none
`include "gpr_regs.svh"
module gpr_ramp_engine_bench;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic neg_gnd = 1'b0;
  wire [11:0] awaddr, araddr;
  wire [31:0] wdata, rdata;
  wire [3:0] wstrb;
  wire [1:0] bresp, rresp, cut;
  wire [8:0] gain;
  wire awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready;
  wire rvalid, rready, start, busy, clamp, cbuf, ev, od;
  logic [65:0] rq[$];
  logic [8:0] gv[$];
  int gd[$];
  int failures = 0, tests_run = 0, cyc = 0;
  integer seed = 32'hc791_4475;
  logic [8:0] prev = 9'h000;
  logic [65:0] e;
  logic [1:0] r;
  logic [5:0] c;
  logic [2:0] f;
  logic [7:0] ix [9] = '{`GPR_IDX_GEN, `GPR_IDX_FIXED, `GPR_IDX_COARSE, `GPR_IDX_SLOPE,
    `GPR_IDX_CTRL, `GPR_IDX_START, `GPR_IDX_INDEX, `GPR_IDX_HOLD, `GPR_IDX_STATUS};
  always #25 aclk = ~aclk;
  gpr_host i_host (.aclk(aclk), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rresp(rresp), .rvalid(rvalid), .rready(rready), .start_pulse(start));
  gpr_ramp_engine i_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awprot(3'b000), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arprot(3'b000), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .start_pulse(start),
    .clock_input_negative_grounded(neg_gnd), .gain_code(gain), .engine_busy(busy),
    .clamp_enable(clamp), .lowpass_cutoff_select(cut), .clock_buffer_enable(cbuf),
    .even_sample_strobe(ev), .odd_sample_strobe(od));
  // ====
  // Checking helpers.
  task automatic chk(input string s, input logic [31:0] x, input logic [31:0] y);
    tests_run++;
    if (y !== x)
    begin
      failures++;
      $display("ERROR %s expected %h seen %h", s, x, y);
    end
  endtask
  task automatic close_out;
    $display("Checks %0d, mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic wr(input logic [7:0] i, input logic [31:0] d, input logic [1:0] er = 2'b00);
    i_host.wr({2'b00, i, 2'b00}, d, r);
    chk("bresp", 32'(er), 32'(r));
    if (r === 2'bxx)
      close_out;
  endtask
  // Read results are noted here and judged by the monitor when the data appears.
  task automatic rd(input logic [7:0] i, input logic [31:0] x,
    input logic [31:0] m = 32'hffff_ffff, input logic [1:0] er = 2'b00);
    rq.push_back({er, m, x});
    i_host.rd({2'b00, i, 2'b00}, r);
    if (r === 2'bxx)
    begin
      failures++;
      close_out;
    end
  endtask
  // Notes n gain changes from v0 by st; d0 and dw are dwell cycles, 0 means not timed.
  task automatic exp_run(input logic [8:0] v0, input int n, input int st, input int dw,
    input int d0);
    for (int k = 1; k <= n; k++)
    begin
      gv.push_back(9'(v0 + k * st));
      gd.push_back(k == 1 ? d0 : dw);
    end
  endtask
  task automatic drain;
    repeat (3000)
      if (gv.size() > 0)
        @(posedge aclk);
    if (gv.size() > 0)
    begin
      failures++;
      close_out;
    end
  endtask
  always @(posedge aclk)
  begin
    if (rvalid && rready && rq.size() > 0)
    begin
      e = rq.pop_front();
      chk("rdata", e[31:0], rdata & e[63:32]);
      chk("rresp", 32'(e[65:64]), 32'(rresp));
    end
    cyc++;
    if (gain !== prev && aresetn && gv.size() > 0)
    begin
      chk("gain", 32'(gv.pop_front()), 32'(gain));
      if (gd[0] != 0)
        chk("dwell", gd[0], cyc);
      void'(gd.pop_front());
    end
    if (gain !== prev)
      cyc = 0;
    prev = gain;
  end
  // ====
  // Main sequence.
  initial
  begin
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    foreach (ix[k]) rd(ix[k], k == 3 ? 32'h1 : 32'h0);
    rd(8'h01, 32'h0, 32'hffff_ffff, 2'b10);
    wr(8'h01, 32'hffff_ffff, 2'b10);
    chk("clamp", 32'h1, 32'(clamp));
    for (int k = 0; k < 4; k++)
    begin
      wr(`GPR_IDX_GEN, 32'h0000_4000 | k);
      chk("cutoff", k == 3 ? 32'h2 : k, 32'(cut));
    end
    chk("clamp", 32'h0, 32'(clamp));
    rd(`GPR_IDX_GEN, 32'h0000_4003);
    chk("cbuf", 32'h1, 32'(cbuf));
    neg_gnd <= 1'b1;
    @(posedge aclk);
    chk("cbuf", 32'h0, 32'(cbuf));
    wr(`GPR_IDX_START, 32'h2);
    wr(`GPR_IDX_INDEX, 32'h0600);
    wr(`GPR_IDX_HOLD, 32'h3);
    wr(`GPR_IDX_CTRL, 32'h1);
    rd(`GPR_IDX_STATUS, 32'h0040_0000, 32'h01ff_0000);
    exp_run(9'd16, 3, 8, 16, 0);
    exp_run(9'd40, 1, -24, 0, 0);
    exp_run(9'd16, 6, 8, 16, 0);
    exp_run(9'd64, 6, -8, 2, 26);
    i_host.pulse();
    repeat (500)
      if (gain !== 9'd40)
        @(posedge aclk);
    chk("gain", 32'd40, 32'(gain));
    chk("busy", 32'h1, 32'(busy));
    i_host.pulse();
    drain();
    repeat (4) @(posedge aclk);
    chk("busy", 32'h0, 32'(busy));
    wr(`GPR_IDX_INDEX, 32'h0005);
    wr(`GPR_IDX_HOLD, 32'h1);
    wr(`GPR_IDX_CTRL, 32'h3);
    rd(`GPR_IDX_STATUS, 32'h0017_0000, 32'h01ff_0000);
    repeat (2)
    begin
      exp_run(9'd16, 7, 1, 2, 0);
      exp_run(9'd23, 1, -7, 0, 8);
    end
    wr(`GPR_IDX_CTRL, 32'h7);
    drain();
    wr(`GPR_IDX_CTRL, 32'h3);
    repeat (200)
      if (busy)
        @(posedge aclk);
    chk("busy", 32'h0, 32'(busy));
    for (int k = 0; k < 4; k++)
    begin
      c = k == 0 ? 6'h00 : k == 1 ? 6'h24 : k == 2 ? 6'h3f : 6'($random(seed));
      f = 3'($random(seed));
      wr(`GPR_IDX_COARSE, 32'(c));
      wr(`GPR_IDX_FIXED, 32'({1'b1, f}));
      rd(`GPR_IDX_STATUS, 32'({((c > 6'h24) ? 6'h24 : c), f}), 32'h0000_03ff);
    end
    // A reset in fixed-gain mode, with the engine idle, must bring the clamp back on after it was switched off.
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    chk("clamp", 32'h1, 32'(clamp));
    chk("gain", 32'h0, 32'(gain));
    close_out;
  end
endmodule
`default_nettype wire
